//--- crtc_apb_slave.sv
// APB read/write strobes with a zero-wait answer
`timescale 1ns/1ps
module crtc_apb_slave (
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic pslverr,
  // Strobes
  input wire logic mapped,
  output logic wr_en,
  output logic rd_en
);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && penable && !pwrite;
endmodule : crtc_apb_slave

//--- crtc_calendar.sv
// Calendar clock with periodic interrupt and 1 Hz pin, APB registers
//
// Functional notes
// - Request flag pends events; write 0 clears
// - Mask bit 1 blocks interrupt output
// - Two priority bits; 00 highest, 11 lowest
// - Control bit 7 runs or halts counters
// - Control bit 5 enables 1 Hz pin
// - Control bit 3 selects 12/24 hour
// - Codes 000 off, 001 half-second, 010 second
// - Codes for minute, hour, day, month
// - Year BCD 00 to 99
// - Month BCD 01 to 12, top bits zero
// - Day BCD 01 to 31, top bits zero
// - Weekday 00 to 06, top bits zero
// - Hour 24h 00-23; 12h uses 12, +20
// - Minute, second 00 to 59, bit 7 zero
// - Latch bit 0 drives pin in output; with control bit 5 set, pin_out shows the 1 Hz phase instead
// - Direction bit 0: 0 output, 1 input
// - Clock enable off holds reset, ignores writes
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "crtc_defines.svh"
module crtc_calendar #(
  parameter int PCLK_HZ = `CRTC_PCLK_HZ,
  parameter int HALF_CYCLES = PCLK_HZ / 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt and pin
  output logic periodic_clock_irq,
  output logic [1:0] irq_level,
  output logic one_hz_pin,
  output logic pin_out,
  output logic pin_oe
);
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic half_tick;
  logic phase;
  logic blk_en_reg;
  logic [7:0] ifl_reg, msk_reg, prh_reg, prl_reg, ctl_reg;
  logic [7:0] year_reg, mon_reg, day_reg, wk_reg, hour_reg;
  logic [7:0] min_reg, sec_reg, port_reg, pdir_reg;
  logic [31:0] rdata_next;
  logic run;
  logic sec_tick;
  logic [7:0] sec_next, min_next, hour_next, day_next, mon_next;
  logic [7:0] wk_next, year_next;
  logic c_min, c_hour, c_day, c_mon, c_year;
  logic evt;
  logic blk_rst_n;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_last(input logic [7:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00) : (y[1:0] == 2'b10);
    case (m)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction : month_last

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  crtc_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .mapped(mapped),
    .wr_en(wr_en),
    .rd_en(rd_en)
  );

  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `CRTC_OFF_STATUS);
  assign run = blk_en_reg && ctl_reg[`CRTC_BIT_RUN];

  // Block enable lives outside the gated reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) blk_en_reg <= 1'b0;
    else if (wr_en && paddr == `CRTC_OFF_CLKEN)
      blk_en_reg <= pwdata[`CRTC_BIT_CLKEN];
  end

  // Register file held in reset while disabled
  assign blk_rst_n = blk_en_reg;

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  // Bus clock stands in for the sub clock here
  crtc_tick_gen #(.HALF_CYCLES(HALF_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .half_tick(half_tick),
    .phase_reg(phase)
  );
  assign sec_tick = half_tick && phase;

  // ------------------------------------------------------------
  // Calendar cascade
  // ------------------------------------------------------------
  always_comb begin
    c_min = (sec_reg == 8'h59);
    sec_next = c_min ? 8'h00 : bcd_inc(sec_reg);
    c_hour = c_min && (min_reg == 8'h59);
    min_next = (min_reg == 8'h59) ? 8'h00 : bcd_inc(min_reg);
    if (ctl_reg[`CRTC_BIT_FMT24]) begin
      c_day = hour_reg == 8'h23;
      hour_next = c_day ? 8'h00 : bcd_inc(hour_reg);
    end else begin
      c_day = hour_reg == 8'h31;
      case (hour_reg)
        8'h31: hour_next = 8'h12;
        8'h11: hour_next = 8'h32;
        8'h12: hour_next = 8'h01;
        8'h32: hour_next = 8'h21;
        default: hour_next = bcd_inc(hour_reg);
      endcase
    end
    c_day = c_day && c_hour;
    c_mon = c_day && (day_reg == month_last(mon_reg, year_reg));
    day_next = (day_reg == month_last(mon_reg, year_reg)) ? 8'h01
               : bcd_inc(day_reg);
    wk_next = (wk_reg == 8'h06) ? 8'h00 : wk_reg + 8'h01;
    c_year = c_mon && (mon_reg == 8'h12);
    mon_next = (mon_reg == 8'h12) ? 8'h01 : bcd_inc(mon_reg);
    year_next = (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
  end

  // ------------------------------------------------------------
  // Periodic event select
  // ------------------------------------------------------------
  always_comb begin
    case (crtc_pkg::crtc_period_e'(ctl_reg[2:0]))
      crtc_pkg::CRTC_PER_OFF: evt = 1'b0;
      crtc_pkg::CRTC_PER_HALF: evt = half_tick;
      crtc_pkg::CRTC_PER_SEC: evt = sec_tick;
      crtc_pkg::CRTC_PER_MIN: evt = sec_tick && c_min;
      crtc_pkg::CRTC_PER_HOUR: evt = sec_tick && c_hour;
      crtc_pkg::CRTC_PER_DAY: evt = sec_tick && c_day;
      default: evt = sec_tick && c_mon;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      ctl_reg <= 8'h00;
      msk_reg <= `CRTC_RST_MASK;
      prh_reg <= `CRTC_RST_PRIO;
      prl_reg <= `CRTC_RST_PRIO;
      port_reg <= 8'h00;
      pdir_reg <= `CRTC_RST_PDIR;
    end else if (wr_en) begin
      case (paddr)
        `CRTC_OFF_CTRL: ctl_reg <= pwdata[7:0] & 8'hAF;
        `CRTC_OFF_MASK: msk_reg <= pwdata[7:0];
        `CRTC_OFF_PRHI: prh_reg <= pwdata[7:0];
        `CRTC_OFF_PRLO: prl_reg <= pwdata[7:0];
        `CRTC_OFF_PORT: port_reg <= pwdata[7:0] & 8'h03;
        `CRTC_OFF_PDIR: pdir_reg <= pwdata[7:0] | 8'hFC;
        default: ;
      endcase
    end
  end

  // Flag: hardware set beats software clear
  always_ff @(posedge pclk or negedge blk_rst_n) begin
    if (!blk_rst_n) ifl_reg <= 8'h00;
    else if (evt) ifl_reg[`CRTC_BIT_IRQ] <= 1'b1;
    else if (wr_en && paddr == `CRTC_OFF_FLAGS)
      ifl_reg <= pwdata[7:0];
  end

  // Writes win over counting in the same cycle
  always_ff @(posedge pclk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      year_reg <= 8'h00;
      mon_reg <= `CRTC_RST_MONTH;
      day_reg <= `CRTC_RST_DAY;
      wk_reg <= 8'h00;
      hour_reg <= `CRTC_RST_HOUR;
      min_reg <= 8'h00;
      sec_reg <= 8'h00;
    end else if (wr_en && paddr >= `CRTC_OFF_YEAR
                 && paddr <= `CRTC_OFF_SEC) begin
      case (paddr)
        `CRTC_OFF_YEAR: year_reg <= pwdata[7:0];
        `CRTC_OFF_MONTH: mon_reg <= pwdata[7:0] & 8'h1F;
        `CRTC_OFF_DAY: day_reg <= pwdata[7:0] & 8'h3F;
        `CRTC_OFF_WEEK: wk_reg <= pwdata[7:0] & 8'h07;
        `CRTC_OFF_HOUR: hour_reg <= pwdata[7:0] & 8'h3F;
        `CRTC_OFF_MIN: min_reg <= pwdata[7:0] & 8'h7F;
        default: sec_reg <= pwdata[7:0] & 8'h7F;
      endcase
    end else if (sec_tick) begin
      sec_reg <= sec_next;
      if (c_min) min_reg <= min_next;
      if (c_hour) hour_reg <= hour_next;
      if (c_day) begin
        day_reg <= day_next;
        wk_reg <= wk_next;
      end
      if (c_mon) mon_reg <= mon_next;
      if (c_year) year_reg <= year_next;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0;
    case (paddr)
      `CRTC_OFF_FLAGS: rdata_next[7:0] = ifl_reg;
      `CRTC_OFF_MASK: rdata_next[7:0] = msk_reg;
      `CRTC_OFF_PRHI: rdata_next[7:0] = prh_reg;
      `CRTC_OFF_PRLO: rdata_next[7:0] = prl_reg;
      `CRTC_OFF_CTRL: rdata_next[7:0] = ctl_reg;
      `CRTC_OFF_YEAR: rdata_next[7:0] = year_reg;
      `CRTC_OFF_MONTH: rdata_next[7:0] = mon_reg;
      `CRTC_OFF_DAY: rdata_next[7:0] = day_reg;
      `CRTC_OFF_WEEK: rdata_next[7:0] = wk_reg;
      `CRTC_OFF_HOUR: rdata_next[7:0] = hour_reg;
      `CRTC_OFF_MIN: rdata_next[7:0] = min_reg;
      `CRTC_OFF_SEC: rdata_next[7:0] = sec_reg;
      `CRTC_OFF_PORT: rdata_next[7:0] = port_reg;
      `CRTC_OFF_PDIR: rdata_next[7:0] = pdir_reg;
      `CRTC_OFF_CLKEN: rdata_next[7] = blk_en_reg;
      `CRTC_OFF_STATUS: rdata_next[1:0] = {phase, run};
      default: rdata_next = 32'h0;
    endcase
  end
  assign prdata = rd_en ? rdata_next : 32'h0;

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign periodic_clock_irq = ifl_reg[`CRTC_BIT_IRQ]
                              && !msk_reg[`CRTC_BIT_IRQ];
  assign irq_level = {prh_reg[`CRTC_BIT_IRQ],
                      prl_reg[`CRTC_BIT_IRQ]};
  assign one_hz_pin = ctl_reg[`CRTC_BIT_ONEHZ] && phase;
  // Pin shows 1 Hz when enabled, else the latch
  assign pin_out = ctl_reg[`CRTC_BIT_ONEHZ] ? phase : port_reg[0];
  assign pin_oe = !pdir_reg[0];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    evt && blk_en_reg |=> ifl_reg[1])
    else $error("flag not set");
  AST_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    msk_reg[1] |-> !periodic_clock_irq)
    else $error("masked irq seen");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_reg[7] && !wr_en |=> $stable(sec_reg))
    else $error("seconds moved while halted");
  AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[2:0] == 3'b000 |-> !evt)
    else $error("event with code 000");
  AST_SEC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    sec_tick && sec_reg == 8'h59 && !wr_en |=> sec_reg == 8'h00)
    else $error("second wrap");
  AST_WEEK: assert property (@(posedge pclk) disable iff (!presetn)
    sec_tick && c_day && wk_reg == 8'h06 && !wr_en
    |=> wk_reg == 8'h00)
    else $error("weekday wrap");
  AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    !blk_en_reg |-> ctl_reg == 8'h00 && !periodic_clock_irq)
    else $error("block active while disabled");
  AST_HOUR24: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[3] && sec_tick && c_hour && hour_reg == 8'h23 && !wr_en
    |=> hour_reg == 8'h00)
    else $error("24h wrap");
endmodule : crtc_calendar

//--- crtc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CRTC_DEFINES_SVH
`define CRTC_DEFINES_SVH
`define CRTC_OFF_FLAGS    12'h000
`define CRTC_OFF_MASK     12'h004
`define CRTC_OFF_PRHI     12'h008
`define CRTC_OFF_PRLO     12'h00C
`define CRTC_OFF_CTRL     12'h010
`define CRTC_OFF_YEAR     12'h014
`define CRTC_OFF_MONTH    12'h018
`define CRTC_OFF_DAY      12'h01C
`define CRTC_OFF_WEEK     12'h020
`define CRTC_OFF_HOUR     12'h024
`define CRTC_OFF_MIN      12'h028
`define CRTC_OFF_SEC      12'h02C
`define CRTC_OFF_PORT     12'h030
`define CRTC_OFF_PDIR     12'h034
`define CRTC_OFF_CLKEN    12'h038
`define CRTC_OFF_STATUS   12'h03C
`define CRTC_BIT_IRQ      1
`define CRTC_BIT_RUN      7
`define CRTC_BIT_ONEHZ    5
`define CRTC_BIT_FMT24    3
`define CRTC_BIT_CLKEN    7
`define CRTC_RST_MASK     8'hFF
`define CRTC_RST_PRIO     8'hFF
`define CRTC_RST_PDIR     8'hFF
`define CRTC_RST_MONTH    8'h01
`define CRTC_RST_DAY      8'h01
`define CRTC_RST_HOUR     8'h12
`define CRTC_SUB_HZ       32768
`define CRTC_PCLK_HZ      40000000
`endif

//--- crtc_pkg.sv
// Types shared by the calendar clock files
package crtc_pkg;
  typedef enum logic [2:0] {
    CRTC_PER_OFF, CRTC_PER_HALF, CRTC_PER_SEC, CRTC_PER_MIN,
    CRTC_PER_HOUR, CRTC_PER_DAY, CRTC_PER_MON0, CRTC_PER_MON1
  } crtc_period_e;
  typedef logic [7:0] crtc_byte_t;
endpackage : crtc_pkg

//--- crtc_tick_gen.sv
// Half-second tick generator from the bus clock
`timescale 1ns/1ps
module crtc_tick_gen #(
  parameter int HALF_CYCLES = 20000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  // Ticks
  output logic half_tick,
  output logic phase_reg
);
  logic [31:0] cnt_reg;
  // Refused at elaboration: the counter needs at least two states
  if (HALF_CYCLES < 2) begin : g_bad_half
    $error("HALF_CYCLES too small");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
      phase_reg <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg == 32'(HALF_CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      phase_reg <= ~phase_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
  assign half_tick = run && (cnt_reg == 32'(HALF_CYCLES - 1));
endmodule : crtc_tick_gen

//--- test_calendar_rtc_with_periodic_irq.sv
// Self-checking bench for the calendar clock block
`timescale 1ns/1ps
module test_calendar_rtc_with_periodic_irq;
  // ----
  // Signals
  // ----
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, one_hz, pin_out, pin_oe, err;
  logic [1:0] lvl;
  logic [31:0] seed = 32'h10;
  int errors = 0;
  int checks = 0;
  int hi;
  int yv;

  // Short half second keeps a full second at 8 cycles
  crtc_calendar #(.HALF_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periodic_clock_irq(irq),
    .irq_level(lvl), .one_hz_pin(one_hz), .pin_out(pin_out),
    .pin_oe(pin_oe));

  // Bus clock stands in for the sub clock time base
  always #12.5 pclk = ~pclk;

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs are looked at once settled
    @(negedge pclk);
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdc

  task automatic wsec(input logic [7:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h02C, 8'h00);
      n++;
    end while (rd[7:0] !== s && n < 60);
    if (n >= 60) begin
      errors++;
      end_sim();
    end
  endtask : wsec

  task automatic ld(input logic [7:0] y, mo, d, wk, h, mi, s);
    apb(1'b1, 12'h014, y);
    apb(1'b1, 12'h018, mo);
    apb(1'b1, 12'h01C, d);
    apb(1'b1, 12'h020, wk);
    apb(1'b1, 12'h024, h);
    apb(1'b1, 12'h028, mi);
    apb(1'b1, 12'h02C, s);
  endtask : ld

  task automatic roll(input logic [7:0] y, mo, d, wk, h, f,
                      input logic [7:0] ey, emo, ed, ewk, eh);
    apb(1'b1, 12'h010, 8'h00);
    ld(y, mo, d, wk, h, 8'h59, 8'h59);
    apb(1'b1, 12'h010, 8'h80 | f);
    wsec(8'h00);
    rdc(12'h024, eh);
    rdc(12'h020, ewk);
    rdc(12'h01C, ed);
    rdc(12'h018, emo);
    rdc(12'h014, ey);
    rdc(12'h028, 8'h00);
  endtask : roll

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h010, 8'h80);
    rdc(12'h010, 8'h00);
    rdc(12'h004, 8'hFF);
    rdc(12'h008, 8'hFF);
    rdc(12'h00C, 8'hFF);
    rdc(12'h034, 8'hFF);
    rdc(12'h018, 8'h01);
    rdc(12'h01C, 8'h01);
    rdc(12'h024, 8'h12);
    chk({30'h0, lvl}, 32'h3);
    chk({30'h0, irq, pin_oe}, 32'h0);
    apb(1'b1, 12'h038, 8'h80);
    apb(1'b0, 12'h040, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h010, 8'hFF);
    rdc(12'h010, 8'hAF);
    apb(1'b1, 12'h010, 8'h08);
    // Random loads must hold while halted
    for (int i = 0; i < 6; i++) begin
      hi = int'(xs() % 60);
      yv = int'(xs() % 100);
      apb(1'b1, 12'h014, bcd(yv));
      apb(1'b0, 12'h014, 8'h00);
      chk(rd, {24'h0, bcd(yv)});
      apb(1'b1, 12'h02C, bcd(hi));
      repeat (20) @(posedge pclk);
      rdc(12'h02C, bcd(hi));
    end
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 12'h008, {6'h0, p[1], 1'b0});
      apb(1'b1, 12'h00C, {6'h0, p[0], 1'b0});
      chk({30'h0, lvl}, p);
    end
    apb(1'b1, 12'h034, 8'h00);
    chk({31'h0, pin_oe}, 32'h1);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 12'h030, 8'(b));
      chk({30'h0, one_hz, pin_out}, b);
    end
    apb(1'b1, 12'h010, 8'hA0);
    hi = 0;
    repeat (24) begin
      @(posedge pclk);
      #1;
      hi += int'(one_hz);
      chk({31'h0, pin_out}, {31'h0, one_hz});
    end
    chk(hi, 12);
    apb(1'b1, 12'h034, 8'h01);
    chk({31'h0, pin_oe}, 32'h0);
    // Every period code against one month-end midnight boundary
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h010, 8'h08);
      ld(8'h24, 8'h01, 8'h31, 8'h03, 8'h23, 8'h59, 8'h58);
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h010, 8'h88 | 8'(c));
      wsec(8'h59);
      // Halt before the rollover so the clear cannot race it
      apb(1'b1, 12'h010, 8'h08);
      rdc(12'h000, (c == 1 || c == 2) ? 8'h02 : 8'h00);
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h010, 8'h88 | 8'(c));
      wsec(8'h00);
      rdc(12'h000, (c != 0) ? 8'h02 : 8'h00);
    end
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h004, 8'h00);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h000, 8'h00);
    chk({31'h0, irq}, 32'h0);
    roll(8'h23, 8'h02, 8'h28, 8'h06, 8'h23, 8'h08,
         8'h23, 8'h03, 8'h01, 8'h00, 8'h00);
    roll(8'h24, 8'h02, 8'h28, 8'h03, 8'h23, 8'h08,
         8'h24, 8'h02, 8'h29, 8'h04, 8'h00);
    roll(8'h99, 8'h12, 8'h31, 8'h05, 8'h31, 8'h00,
         8'h00, 8'h01, 8'h01, 8'h06, 8'h12);
    roll(8'h24, 8'h04, 8'h30, 8'h02, 8'h11, 8'h00,
         8'h24, 8'h04, 8'h30, 8'h02, 8'h32);
    roll(8'h24, 8'h04, 8'h30, 8'h02, 8'h23, 8'h08,
         8'h24, 8'h05, 8'h01, 8'h03, 8'h00);
    end_sim();
  end
endmodule : test_calendar_rtc_with_periodic_irq
